/* File: rtl/osa_pkg.sv */
/*
 constants shared by the oversampling average filter and its output fifo.
 assumes a 125 MHz mclk and an adc core that returns eight 18-bit results per sample.
*/
package osa_pkg;
	localparam int CHANNELS = 8;
	localparam int CHAN_W = 3;
	localparam int DATA_W = 18;
	localparam int ACC_W = 24;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W = CHAN_W + DATA_W;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MAX_RATE_KSPS = 500;
	// least spacing between two sampling strobes at full throughput
	localparam int SAMPLE_PERIOD_NS = 1000000 / MAX_RATE_KSPS;
	localparam logic [7:0] PACE_CYCLES =
		8'((SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] OS_NONE = 3'h0;
	localparam logic [2:0] OS_INVALID = 3'h7;
	localparam logic [CHAN_W-1:0] LAST_CHAN = 3'h7;
	localparam logic [7:0] PACE_RESET = 8'h00;
endpackage : osa_pkg

/* File: rtl/sample_fifo.sv */
/*
 synchronous fifo of flip-flops with valid/ready on both sides.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sample_fifo #(
	parameter int W = 21,
	parameter int D = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_s;
	fifo_s st_r;
	fifo_s st_nxt;
	logic push;
	logic pop;

	assign in_ready = (st_r.cnt != (AW+1)'(D));
	assign out_valid = (st_r.cnt != '0);
	assign out_data = st_r.mem[st_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		st_nxt = st_r;
		if (push)
		begin
			st_nxt.mem[st_r.wp] = in_data;
			st_nxt.wp = AW'(st_r.wp + 1'b1);
		end
		if (pop)
			st_nxt.rp = AW'(st_r.rp + 1'b1);
		if (push && !pop)
			st_nxt.cnt = (AW+1)'(st_r.cnt + 1'b1);
		else if (pop && !push)
			st_nxt.cnt = (AW+1)'(st_r.cnt - 1'b1);
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule : sample_fifo

/* File: rtl/oversampling_average_filter.sv */
/*
 oversampling, averaging and decimation stage of an 8-channel 18-bit adc,
 plus static range and reference selection.
 assumes the adc core answers each sampling strobe with eight results in
 channel order 0..7 on conv_valid/conv_data, and that config pins are synchronous.
*/
`timescale 1ns/1ps
module oversampling_average_filter (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// configuration and conversion start pins
	input wire logic [2:0] oversample_select,
	input wire logic convert_start_first,
	input wire logic convert_start_second,
	input wire logic range_select,
	input wire logic reference_select,
	// adc core
	output logic sample_strobe,
	input wire logic conv_valid,
	input wire logic [osa_pkg::DATA_W-1:0] conv_data,
	// analog control
	output logic input_gain_amplifier,
	output logic ref_internal,
	output logic ref_buffer_en,
	// status
	output logic busy,
	output logic os_invalid,
	// averaged results
	output logic out_valid,
	output logic [osa_pkg::DATA_W-1:0] out_data,
	output logic [osa_pkg::CHAN_W-1:0] out_chan,
	input wire logic out_ready
);
	typedef enum logic [1:0] {IDLE, WAIT_CONV, PACE, EMIT} phase_e;
	typedef struct packed {
		phase_e phase;
		logic start_prev;
		logic [2:0] shift;
		logic [5:0] remain;
		logic [7:0] pace;
		logic [osa_pkg::CHAN_W-1:0] ch;
		logic [osa_pkg::CHANNELS-1:0][osa_pkg::ACC_W-1:0] acc;
		logic strobe;
		logic gain;
		logic ref_int;
		logic ref_buf;
		logic invalid;
		logic busy;
		logic out_v;
		logic [osa_pkg::DATA_W-1:0] out_d;
		logic [osa_pkg::CHAN_W-1:0] out_c;
	} filt_s;
	filt_s st_r;
	filt_s st_nxt;
	logic start_lvl;
	logic start_edge;
	logic push;
	logic push_ready;
	logic [osa_pkg::DATA_W-1:0] mean;
	logic [osa_pkg::FIFO_W-1:0] fifo_out;
	logic fifo_valid;
	logic fifo_pop;

	function automatic logic os_ok(input logic [2:0] code);
		return code != osa_pkg::OS_INVALID;
	endfunction : os_ok

	function automatic logic [5:0] os_extra(input logic [2:0] code);
		return 6'((7'h01 << code) - 7'h01);
	endfunction : os_extra

	assign start_lvl = convert_start_first && convert_start_second;
	assign start_edge = start_lvl && !st_r.start_prev;
	assign push = (st_r.phase == EMIT);
	// output flop refills when empty or being taken
	assign fifo_pop = fifo_valid && (!st_r.out_v || out_ready);
	// arithmetic shift keeps the two's complement sign of the mean
	assign mean = osa_pkg::DATA_W'($signed(st_r.acc[st_r.ch]) >>> st_r.shift);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.start_prev = start_lvl;
		st_nxt.strobe = 1'b0;
		st_nxt.gain = range_select;
		st_nxt.ref_int = reference_select;
		st_nxt.ref_buf = 1'b1;
		st_nxt.invalid = !os_ok(oversample_select);
		if (st_r.pace != '0)
			st_nxt.pace = 8'(st_r.pace - 1'b1);
		if (st_r.out_v && out_ready)
			st_nxt.out_v = 1'b0;
		if (fifo_pop)
		begin
			st_nxt.out_v = 1'b1;
			st_nxt.out_d = fifo_out[osa_pkg::DATA_W-1:0];
			st_nxt.out_c = fifo_out[osa_pkg::FIFO_W-1:osa_pkg::DATA_W];
		end
		case (st_r.phase)
			IDLE:
			begin
				if (start_edge && os_ok(oversample_select))
				begin
					st_nxt.strobe = 1'b1;
					st_nxt.shift = oversample_select;
					st_nxt.remain = os_extra(oversample_select);
					st_nxt.pace = 8'(osa_pkg::PACE_CYCLES - 1'b1);
					st_nxt.ch = '0;
					st_nxt.acc = '0;
					st_nxt.phase = WAIT_CONV;
				end
			end
			WAIT_CONV:
			begin
				if (conv_valid)
				begin
					st_nxt.acc[st_r.ch] = osa_pkg::ACC_W'(st_r.acc[st_r.ch] +
						{{(osa_pkg::ACC_W-osa_pkg::DATA_W){conv_data[osa_pkg::DATA_W-1]}},
						conv_data});
					st_nxt.ch = osa_pkg::CHAN_W'(st_r.ch + 1'b1);
					if (st_r.ch == osa_pkg::LAST_CHAN)
						st_nxt.phase = (st_r.remain == '0) ? EMIT : PACE;
				end
			end
			PACE:
			begin
				if (st_r.pace == '0)
				begin
					st_nxt.strobe = 1'b1;
					st_nxt.remain = 6'(st_r.remain - 1'b1);
					st_nxt.pace = 8'(osa_pkg::PACE_CYCLES - 1'b1);
					st_nxt.phase = WAIT_CONV;
				end
			end
			EMIT:
			begin
				if (push_ready)
				begin
					st_nxt.ch = osa_pkg::CHAN_W'(st_r.ch + 1'b1);
					if (st_r.ch == osa_pkg::LAST_CHAN)
						st_nxt.phase = IDLE;
				end
			end
			default:
				st_nxt.phase = IDLE;
		endcase
		st_nxt.busy = (st_nxt.phase != IDLE);
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	sample_fifo #(
		.W(osa_pkg::FIFO_W),
		.D(osa_pkg::FIFO_DEPTH)
	) i_sample_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(push),
		.in_data({st_r.ch, mean}),
		.in_ready(push_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_out),
		.out_ready(fifo_pop)
	);

	assign out_valid = st_r.out_v;
	assign out_data = st_r.out_d;
	assign out_chan = st_r.out_c;
	assign sample_strobe = st_r.strobe;
	assign busy = st_r.busy;
	assign input_gain_amplifier = st_r.gain;
	assign ref_internal = st_r.ref_int;
	assign ref_buffer_en = st_r.ref_buf;
	assign os_invalid = st_r.invalid;

	a_invalid_flag: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(sys_rst) |-> os_invalid == ($past(oversample_select) == 3'h7))
		else $error("invalid code flag wrong");
	a_start_launch: assert property (@(posedge mclk) disable iff (sys_rst)
		(st_r.phase == IDLE && start_edge && oversample_select != 3'h7)
		|=> sample_strobe && busy)
		else $error("start edge did not launch sampling");
	a_invalid_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
		(st_r.phase == IDLE && oversample_select == 3'h7) |=> !sample_strobe)
		else $error("invalid code started a set");
	a_strobe_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
		sample_strobe |=> (!sample_strobe)[*8])
		else $error("strobes too close");
	a_pace_auto: assert property (@(posedge mclk) disable iff (sys_rst)
		(st_r.phase == PACE && st_r.pace == '0) |=> sample_strobe ##1 st_r.phase == WAIT_CONV)
		else $error("internal strobe missing");
	a_emit_end: assert property (@(posedge mclk) disable iff (sys_rst)
		(push && push_ready && st_r.ch == 3'h7) |=> st_r.phase == IDLE && !busy)
		else $error("set did not end after eighth word");
	a_direct_pass: assert property (@(posedge mclk) disable iff (sys_rst)
		(push && st_r.shift == 3'h0) |-> mean == st_r.acc[st_r.ch][17:0])
		else $error("no-oversampling result altered");
	a_gain_follow: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(sys_rst) |-> input_gain_amplifier == $past(range_select))
		else $error("gain does not follow range");
	a_ref_follow: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(sys_rst) |-> ref_internal == $past(reference_select) && ref_buffer_en)
		else $error("reference select wrong");
	a_out_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(out_valid && !out_ready) |=> out_valid && $stable(out_data) && $stable(out_chan))
		else $error("output word changed before it was taken");
	a_emit_stall: assert property (@(posedge mclk) disable iff (sys_rst)
		(push && !push_ready) |=> push && $stable(st_r.ch))
		else $error("stalled emission moved on");
endmodule : oversampling_average_filter

/* File: tb/adc_core_model.sv */
/*
 adc core stand-in: answers each sampling strobe with eight results.
 assumes strobes come no faster than twelve cycles apart.
*/
`timescale 1ns/1ps
module adc_core_model (
	// clock and strobe
	input wire logic mclk,
	input wire logic sample_strobe,
	// results
	output logic conv_valid,
	output logic [17:0] conv_data
);
	int k = 0;
	int n = 8;
	initial conv_valid = 1'b0;
	initial conv_data = 18'h0;
	// slow start, then one result a cycle; idle data toggles
	always @(posedge mclk)
	begin
		conv_valid <= 1'b0;
		conv_data <= ~conv_data;
		if (sample_strobe)
			n <= -3;
		else if (n < 0)
			n <= n + 1;
		else if (n < 8)
		begin
			conv_valid <= 1'b1;
			conv_data <= 18'(n * 1000 - 4000 + 2 * k);
			n <= n + 1;
			k <= k + 32'(n == 7);
		end
	end
endmodule : adc_core_model

/* File: tb/oversampling_average_filter_tb_top.sv */
/*
 self-checking bench for the averaging filter.
 assumes the core model holds no reset and starts with the bench.
*/
`timescale 1ns/1ps
module oversampling_average_filter_tb_top;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] sel = 3'h0;
	logic cs1 = 1'b0;
	logic cs2 = 1'b0;
	logic rng = 1'b0;
	logic rsel = 1'b0;
	logic rdy = 1'b1;
	logic strobe, cv, busy, inv, gain, refi, bufen, ov;
	logic [17:0] cd, od;
	logic [2:0] oc;
	int num_errors = 0;
	int checks_done = 0;
	int strobes = 0;
	int strobe_base = 0;
	int gap = 0;
	logic [31:0] expq [$];
	always #4 mclk = ~mclk;
	oversampling_average_filter i_oversampling_average_filter (.mclk(mclk), .sys_rst(sys_rst),
		.oversample_select(sel), .convert_start_first(cs1), .convert_start_second(cs2),
		.range_select(rng), .reference_select(rsel), .sample_strobe(strobe),
		.conv_valid(cv), .conv_data(cd), .input_gain_amplifier(gain), .ref_internal(refi),
		.ref_buffer_en(bufen), .busy(busy), .os_invalid(inv), .out_valid(ov),
		.out_data(od), .out_chan(oc), .out_ready(rdy));
	adc_core_model i_adc_core_model (.mclk(mclk), .sample_strobe(strobe), .conv_valid(cv),
		.conv_data(cd));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	always @(posedge mclk)
	begin
		gap <= gap + 1;
		if (strobe)
		begin
			if (strobes > strobe_base)
				chk(32'(gap >= 249), 32'h1);
			gap <= 0;
			strobes <= strobes + 1;
		end
		if (ov && rdy)
			chk(32'({oc, od}), expq.pop_front());
	end
	task automatic wait_idle(input int n);
		int t;
		t = 0;
		while (busy !== 1'b0 && t < n * 300 + 100)
		begin
			@(negedge mclk);
			t++;
		end
		chk(32'(strobes - strobe_base), 32'(n));
		repeat (3) @(negedge mclk);
	endtask : wait_idle
	task automatic start_set(input logic [2:0] code, input bit wait_end);
		int n;
		n = 1 << code;
		@(negedge mclk);
		sel = code;
		strobe_base = strobes;
		for (int c = 0; c < 8; c++)
			expq.push_back(32'({3'(c), 18'(c * 1000 - 4000 + 2 * strobes + n - 1)}));
		{cs1, cs2} = 2'h3;
		@(negedge mclk);
		{cs1, cs2} = 2'h0;
		if (wait_end)
			wait_idle(n);
	endtask : start_set
	task automatic refused(input logic [2:0] code, input logic [1:0] st);
		@(negedge mclk);
		sel = code;
		strobe_base = strobes;
		{cs1, cs2} = st;
		repeat (3) @(negedge mclk);
		chk(32'({inv, busy, 4'(strobes - strobe_base)}), 32'({code == 3'h7, 5'h0}));
		{cs1, cs2} = 2'h0;
	endtask : refused
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (3) @(negedge mclk);
		sys_rst = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			{rng, rsel} = 2'(i);
			repeat (2) @(negedge mclk);
			chk(32'({gain, refi, bufen}), 32'({rng, rsel, 1'b1}));
		end
		$display("pin test done");
		for (int c = 0; c < 7; c++)
			start_set(3'(c), 1'b1);
		$display("ratio test done");
		refused(3'h7, 2'h3);
		refused(3'h0, 2'h2);
		refused(3'h0, 2'h1);
		$display("refusal test done");
		rdy = 1'b0;
		start_set(3'h0, 1'b1);
		start_set(3'h1, 1'b1);
		start_set(3'h0, 1'b0);
		repeat (400) @(negedge mclk);
		chk(32'({busy, ov}), 32'h3);
		rdy = 1'b1;
		wait_idle(1);
		// a full fifo still drains after the last push
		for (int t = 0; t < 40 && ov; t++)
			@(negedge mclk);
		chk(32'(expq.size()), 32'h0);
		$display("fifo test done");
		give_verdict();
	end
	initial
	begin
		#480000;
		num_errors++;
		give_verdict();
	end
endmodule : oversampling_average_filter_tb_top
